// [hdl/twcp_pkg.sv]
// Constants, types and register map for the two-wire configuration port host.
// Assumes a 100 MHz system clock; the serial clock is derived from it.
package twcp_pkg;

  // ==========================================================================
  // Timing
  localparam int CLK_MHZ  = 100;
  // 250 kHz bit rate keeps a full bench run short and still clears the 3-period filter
  localparam int QTR_NS   = 1000;
  localparam int QTR_CYC  = (QTR_NS * CLK_MHZ + 999) / 1000;
  localparam logic [8:0] QTR_LAST = 9'(QTR_CYC - 1);
  localparam int RST_NS   = 4000;
  localparam int RST_QTRS = (RST_NS + QTR_NS - 1) / QTR_NS;
  localparam logic [3:0] RST_LOW_LAST = 4'(RST_QTRS - 1);
  localparam logic [3:0] RST_END_LAST = 4'(2 * RST_QTRS - 1);

  // ==========================================================================
  // Bus addressing and register map of the device
  localparam logic [5:0] DEV_ADDR_HI  = 6'h26;
  localparam logic       DIR_WRITE    = 1'h0;
  localparam logic       DIR_READ     = 1'h1;
  localparam logic [7:0] REG_PLL_VIDEO_TUNING    = 8'h1C;
  localparam logic [7:0] REG_BLACK_LEVEL_RESTORE = 8'h23;
  localparam logic [7:0] REG_CRYSTAL_COMP        = 8'h2B;
  localparam logic [7:0] VAL_PLL_VIDEO_TUNING    = 8'h49;
  localparam logic [7:0] VAL_BLACK_LEVEL_RESTORE = 8'h78;
  localparam logic [1:0] INIT_LAST    = 2'h2;
  localparam logic [3:0] ACK_BIT      = 4'h8;

  // ==========================================================================
  // Types
  typedef struct packed {
    logic       rd;
    logic [7:0] ptr;
    logic [7:0] data;
    logic [4:0] count;
  } twcp_cmd_type;

  typedef enum logic [4:0] {
    ST_IDLE  = 5'h01,
    ST_START = 5'h02,
    ST_BITS  = 5'h04,
    ST_STOP  = 5'h08,
    ST_RST   = 5'h10
  } twcp_state_type;

  typedef enum logic [4:0] {
    STG_ADDR_W = 5'h01,
    STG_PTR    = 5'h02,
    STG_DATA   = 5'h04,
    STG_ADDR_R = 5'h08,
    STG_READ   = 5'h10
  } twcp_stage_type;

endpackage

// [hdl/twcp_host.sv]
// Host controller for the two-wire configuration port of a video digitizer.
// Drives the serial clock, shares the open-drain data line, pulses the reset pin.
// Assumes the board resolves sda from sda_oe (low when driven) and a pull-up.
// Overview of operation
// RQ1: Device address is 100110 plus select bit
// RQ2: Idle bus high; data line never driven high
// RQ3: Open each transfer with start condition
// RQ4: Device ignores traffic until a start
// RQ5: Send seven-bit address then direction bit
// RQ6: Device acknowledges matching address
// RQ7: End with stop or repeated start
// RQ8: Keep data stable while clock high
// RQ9: Device deglitches clock by three crystal periods
// RQ10: Device samples data on delayed rising edge
// RQ11: Device changes read data after falling edge
// RQ12: Write: address, pointer, data, pointer increments
// RQ13: Read: pointer write, restart, read bytes
// RQ14: Sequential reads return ascending registers
// RQ15: Device defaults select RGB, first channel
// RQ16: Write 0x49 to pll_video_tuning
// RQ17: Write 0x78 to black_level_restore_ctrl
// RQ18: Write crystal compensation value to 0x2B
// RQ19: Device resets itself at power-up
// RQ20: Reset pin equals power-up reset
// RQ21: Serial port works in standby
// RQ22: Do not acknowledge final read byte
`timescale 1ns/1ps

module twcp_host
  import twcp_pkg::*;
(
  input  wire logic         sys_clk,
  input  wire logic         rst_b,
  input  wire logic         cmd_valid,
  input  wire twcp_cmd_type cmd,
  input  wire logic         init_req,
  input  wire logic [7:0]   crystal_comp,
  input  wire logic         dev_reset_req,
  input  wire logic         addr_sel,
  output logic              cmd_ready,
  output logic              done,
  output logic              nack_err,
  output logic              rd_valid,
  output logic [7:0]        rd_data,
  output logic              scl_out,
  input  wire logic         sda_in,
  output logic              sda_out,
  output logic              sda_oe,
  output logic              dev_reset_n
);

  // ==========================================================================
  // Pin synchronisers
  logic sda_m_q;
  logic sda_s_q;
  logic sel_m_q;
  logic sel_s_q;

  always_ff @(posedge sys_clk) begin
    if (!rst_b) begin
      sda_m_q <= 1'h1;
      sda_s_q <= 1'h1;
      sel_m_q <= 1'h0;
      sel_s_q <= 1'h0;
    end else begin
      sda_m_q <= sda_in;
      sda_s_q <= sda_m_q;
      sel_m_q <= addr_sel;
      sel_s_q <= sel_m_q;
    end
  end

  // ==========================================================================
  // Quarter-bit timer
  twcp_state_type st_q;
  logic [8:0]     qc_q;
  logic           tick;

  assign tick = (qc_q == QTR_LAST);

  always_ff @(posedge sys_clk) begin
    if (!rst_b) begin
      qc_q <= 9'h000;
    end else if (st_q == ST_IDLE || tick) begin
      qc_q <= 9'h000;
    end else begin
      qc_q <= qc_q + 9'h001;
    end
  end

  // ==========================================================================
  // Transfer sequencer
  twcp_stage_type stage_q;
  twcp_cmd_type   cur_q;
  logic [1:0]     ph_q;
  logic [3:0]     bit_q;
  logic [7:0]     sh_q;
  logic [4:0]     rem_q;
  logic           init_q;
  logic [1:0]     idx_q;
  logic [7:0]     comp_q;
  logic           scl_q;
  logic           oe_q;
  logic           ready_q;
  logic           done_q;
  logic           err_q;
  logic           rdv_q;
  logic [7:0]     rdd_q;
  logic           rstn_q;
  logic           sdo_q;
  logic [6:0]     dev_addr;
  logic           ack;

  assign dev_addr = {DEV_ADDR_HI, sel_s_q}; // RQ1
  assign ack      = !sda_s_q;

  // Recommended start-up writes, in order
  function automatic twcp_cmd_type init_cmd(input logic [1:0] idx, input logic [7:0] comp);
    twcp_cmd_type c;
    c.rd    = DIR_WRITE;
    c.count = 5'h01;
    c.ptr   = REG_CRYSTAL_COMP;
    c.data  = comp;
    if (idx == 2'h0) begin
      c.ptr  = REG_PLL_VIDEO_TUNING;
      c.data = VAL_PLL_VIDEO_TUNING;
    end else if (idx == 2'h1) begin
      c.ptr  = REG_BLACK_LEVEL_RESTORE;
      c.data = VAL_BLACK_LEVEL_RESTORE;
    end
    return c;
  endfunction

  always_ff @(posedge sys_clk) begin
    if (!rst_b) begin
      st_q    <= ST_IDLE;
      stage_q <= STG_ADDR_W;
      cur_q   <= '0;
      ph_q    <= 2'h0;
      bit_q   <= 4'h0;
      sh_q    <= 8'h00;
      rem_q   <= 5'h00;
      init_q  <= 1'h0;
      idx_q   <= 2'h0;
      comp_q  <= 8'h00;
      scl_q   <= 1'h1;
      oe_q    <= 1'h0;
      ready_q <= 1'h1;
      done_q  <= 1'h0;
      err_q   <= 1'h0;
      rdv_q   <= 1'h0;
      rdd_q   <= 8'h00;
      rstn_q  <= 1'h1;
      sdo_q   <= 1'h0;
    end else begin
      done_q <= 1'h0;
      rdv_q  <= 1'h0;
      sdo_q  <= 1'h0; // RQ2
      unique case (st_q)
        ST_IDLE: begin
          scl_q <= 1'h1; // RQ2
          oe_q  <= 1'h0;
          ph_q  <= 2'h0;
          bit_q <= 4'h0;
          if (ready_q && dev_reset_req) begin
            rstn_q  <= 1'h0; // RQ20
            ready_q <= 1'h0;
            st_q    <= ST_RST;
          end else if (ready_q && init_req) begin
            init_q  <= 1'h1;
            idx_q   <= 2'h0;
            comp_q  <= crystal_comp;
            cur_q   <= init_cmd(2'h0, crystal_comp); // RQ16
            err_q   <= 1'h0;
            ready_q <= 1'h0;
            stage_q <= STG_ADDR_W;
            st_q    <= ST_START;
          end else if (ready_q && cmd_valid) begin
            init_q  <= 1'h0;
            cur_q   <= cmd;
            err_q   <= 1'h0;
            ready_q <= 1'h0;
            stage_q <= STG_ADDR_W;
            st_q    <= ST_START;
          end
        end
        ST_START: if (tick) begin
          // Release data, raise clock, then pull data low under a high clock
          ph_q <= ph_q + 2'h1;
          unique case (ph_q)
            2'h0: oe_q  <= 1'h0;
            2'h1: scl_q <= 1'h1;
            2'h2: oe_q  <= 1'h1; // RQ3
            2'h3: begin
              scl_q <= 1'h0;
              bit_q <= 4'h0;
              sh_q  <= {dev_addr, stage_q == STG_ADDR_R}; // RQ5
              st_q  <= ST_BITS;
            end
          endcase
        end
        ST_BITS: if (tick) begin
          ph_q <= ph_q + 2'h1;
          unique case (ph_q)
            2'h0: begin
              // Data moves a quarter bit after the clock fell, clear of device hold
              if (bit_q == ACK_BIT) begin
                oe_q <= (stage_q == STG_READ) && (rem_q > 5'h01); // RQ22
              end else begin
                oe_q <= (stage_q != STG_READ) && !sh_q[7]; // RQ8
              end
            end
            2'h1: scl_q <= 1'h1;
            2'h2: ;
            2'h3: begin
              scl_q <= 1'h0;
              if (bit_q != ACK_BIT) begin
                bit_q <= bit_q + 4'h1;
                sh_q  <= {sh_q[6:0], sda_s_q};
              end else begin
                bit_q <= 4'h0;
                unique case (stage_q)
                  STG_ADDR_W: begin
                    if (!ack) begin
                      err_q <= 1'h1;
                      st_q  <= ST_STOP;
                    end else begin
                      stage_q <= STG_PTR;
                      sh_q    <= cur_q.ptr; // RQ12
                    end
                  end
                  STG_PTR: begin
                    if (!ack) begin
                      err_q <= 1'h1;
                      st_q  <= ST_STOP;
                    end else if (cur_q.rd) begin
                      stage_q <= STG_ADDR_R; // RQ13
                      st_q    <= ST_START;
                    end else begin
                      stage_q <= STG_DATA;
                      sh_q    <= cur_q.data;
                    end
                  end
                  STG_DATA: begin
                    err_q <= !ack;
                    st_q  <= ST_STOP; // RQ7
                  end
                  STG_ADDR_R: begin
                    if (!ack) begin
                      err_q <= 1'h1;
                      st_q  <= ST_STOP;
                    end else begin
                      stage_q <= STG_READ;
                      rem_q   <= (cur_q.count == 5'h00) ? 5'h01 : cur_q.count;
                    end
                  end
                  STG_READ: begin
                    rdv_q <= 1'h1; // RQ13
                    rdd_q <= sh_q;
                    rem_q <= rem_q - 5'h01;
                    if (rem_q == 5'h01) begin
                      st_q <= ST_STOP;
                    end
                  end
                  default: st_q <= ST_STOP;
                endcase
              end
            end
          endcase
        end
        ST_STOP: if (tick) begin
          ph_q <= ph_q + 2'h1;
          unique case (ph_q)
            2'h0: oe_q  <= 1'h1;
            2'h1: scl_q <= 1'h1;
            2'h2: oe_q  <= 1'h0; // RQ7
            2'h3: begin
              // Last quarter leaves the bus free before any next start
              if (init_q && !err_q && idx_q != INIT_LAST) begin
                idx_q   <= idx_q + 2'h1;
                cur_q   <= init_cmd(idx_q + 2'h1, comp_q); // RQ17 RQ18
                stage_q <= STG_ADDR_W;
                st_q    <= ST_START;
              end else begin
                init_q  <= 1'h0;
                ready_q <= 1'h1;
                done_q  <= 1'h1;
                st_q    <= ST_IDLE;
              end
            end
          endcase
        end
        ST_RST: if (tick) begin
          bit_q <= bit_q + 4'h1;
          if (bit_q == RST_LOW_LAST) begin
            rstn_q <= 1'h1;
          end
          // Idle as long again so the device settles to its defaults
          if (bit_q == RST_END_LAST) begin
            bit_q   <= 4'h0;
            ready_q <= 1'h1;
            done_q  <= 1'h1;
            st_q    <= ST_IDLE;
          end
        end
        default: st_q <= ST_IDLE;
      endcase
    end
  end

  assign cmd_ready   = ready_q;
  assign done        = done_q;
  assign nack_err    = err_q;
  assign rd_valid    = rdv_q;
  assign rd_data     = rdd_q;
  assign scl_out     = scl_q;
  assign sda_out     = sdo_q;
  assign sda_oe      = oe_q;
  assign dev_reset_n = rstn_q;

  // ==========================================================================
  // Assertions
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rst_b);

  property p_idle_bus;
    st_q == ST_IDLE && $past(st_q) == ST_IDLE |-> scl_q && !oe_q && !sdo_q;
  endproperty
  a_idle_bus: assert property (p_idle_bus) else $error("idle bus not released"); // RQ2

  property p_start_cond;
    $rose(oe_q) && scl_q && $past(scl_q) |-> st_q == ST_START && $past(ph_q) == 2'h2;
  endproperty
  a_start_cond: assert property (p_start_cond) else $error("data fell under high clock"); // RQ3

  property p_addr_byte;
    st_q == ST_BITS && bit_q == 4'h0 && ph_q == 2'h0 && stage_q == STG_ADDR_W
      |-> sh_q == {DEV_ADDR_HI, sel_s_q, DIR_WRITE};
  endproperty
  a_addr_byte: assert property (p_addr_byte) else $error("bad write address byte"); // RQ5

  property p_stop_cond;
    $fell(oe_q) && scl_q |-> st_q == ST_STOP ##1 !oe_q;
  endproperty
  a_stop_cond: assert property (p_stop_cond) else $error("data rose under high clock"); // RQ7

  property p_stable_high;
    st_q == ST_BITS && scl_q && $past(scl_q) |-> $stable(oe_q);
  endproperty
  a_stable_high: assert property (p_stable_high) else $error("data moved while clock high"); // RQ8

  property p_data_byte;
    st_q == ST_BITS && bit_q == 4'h0 && ph_q == 2'h0 && stage_q == STG_DATA
      |-> sh_q == cur_q.data && !cur_q.rd;
  endproperty
  a_data_byte: assert property (p_data_byte) else $error("wrong data byte"); // RQ12

  property p_read_addr;
    st_q == ST_BITS && bit_q == 4'h0 && ph_q == 2'h0 && stage_q == STG_ADDR_R
      |-> sh_q == {DEV_ADDR_HI, sel_s_q, DIR_READ} && cur_q.rd;
  endproperty
  a_read_addr: assert property (p_read_addr) else $error("bad read address byte"); // RQ13

  property p_init_first;
    init_q && idx_q == 2'h0 |-> cur_q.ptr == 8'h1C && cur_q.data == 8'h49;
  endproperty
  a_init_first: assert property (p_init_first) else $error("wrong loop tuning write"); // RQ16

  property p_init_second;
    init_q && idx_q == 2'h1 |-> cur_q.ptr == 8'h23 && cur_q.data == 8'h78;
  endproperty
  a_init_second: assert property (p_init_second) else $error("wrong restore write"); // RQ17

  property p_init_third;
    init_q && idx_q == 2'h2 |-> cur_q.ptr == 8'h2B && cur_q.data == comp_q;
  endproperty
  a_init_third: assert property (p_init_third) else $error("wrong compensation write"); // RQ18

  property p_last_nack;
    st_q == ST_BITS && stage_q == STG_READ && bit_q == ACK_BIT && ph_q == 2'h2 && rem_q == 5'h01
      |-> !oe_q;
  endproperty
  a_last_nack: assert property (p_last_nack) else $error("final read byte acknowledged"); // RQ22

  c_write: cover property (st_q == ST_STOP && stage_q == STG_DATA && tick && ph_q == 2'h3);
  c_read:  cover property (rdv_q && rem_q == 5'h00);
  c_init:  cover property (done_q && $past(idx_q) == INIT_LAST);
  c_reset: cover property ($rose(rstn_q));

endmodule

// [testbench/twcp_dev_model.sv]
// Behavioural model of the digitizer's two-wire configuration port.
// Assumes the host drives scl, sda is resolved with a pull-up, xtal_clk runs free.
`timescale 1ns/1ps

module twcp_dev_model
  import twcp_pkg::*;
(
  input  wire logic xtal_clk,
  input  wire logic reset_n,
  input  wire logic addr_sel,
  input  wire logic scl,
  input  wire logic sda,
  output logic      pull
);
  // ==========================================================================
  // Register file and bus state
  logic [7:0] regs [256];
  logic [7:0] ptr, sh, ob;
  logic [2:0] sc, sd;
  logic [3:0] bitn;
  logic [1:0] stg;
  logic       rd, act, lvl_q, lvl_p;
  logic       por_q = 1'b0;
  wire        hi    = lvl_q & lvl_p;
  wire        rise  = lvl_q & ~lvl_p;
  wire        fall  = ~lvl_q & lvl_p;
  wire        start = hi & sd[2] & ~sd[1];
  wire        stop  = hi & ~sd[2] & sd[1];

  // ==========================================================================
  // Clock filter: a level must hold three crystal periods before it counts
  // Runs from the crystal alone, so the port stays usable in standby
  always @(posedge xtal_clk) begin
    sc    <= {sc[1:0], scl};
    sd    <= {sd[1:0], sda};
    lvl_q <= (sc == 3'h7) ? 1'b1 : ((sc == 3'h0) ? 1'b0 : lvl_q);
    lvl_p <= lvl_q;
  end

  // ==========================================================================
  // Protocol engine
  always @(posedge xtal_clk) begin
    if (!reset_n || !por_q) begin
      for (int i = 0; i < 256; i++) regs[i] <= 8'(~i);
      por_q <= 1'b1;
      act   <= 1'b0;
      pull  <= 1'b0;
      ptr   <= 8'h00;
    end else if (start) begin
      act  <= 1'b1;
      // The clock fall that closes the start is not a data bit
      bitn <= 4'hF;
      stg  <= 2'h0;
      rd   <= 1'b0;
      pull <= 1'b0;
    end else if (stop) begin
      act  <= 1'b0;
      pull <= 1'b0;
    end else if (act && rise) begin
      if (bitn < 4'h8) sh <= {sh[6:0], sd[2]};
      else if (rd && sd[2]) act <= 1'b0;
    end else if (act && fall) begin
      bitn <= (bitn == 4'h8) ? 4'h0 : bitn + 4'h1;
      if (bitn == 4'h8) begin
        pull <= rd & ~regs[ptr][7];
        ob   <= {regs[ptr][6:0], 1'b1};
        stg  <= (stg == 2'h0 && !rd) ? 2'h1 : 2'h2;
      end else if (rd && stg == 2'h2) begin
        pull <= (bitn == 4'h7) ? 1'b0 : ~ob[7];
        ob   <= {ob[6:0], 1'b1};
        if (bitn == 4'h7) ptr <= ptr + 8'h01;
      end else if (bitn == 4'h7) begin
        pull <= 1'b1;
        if (stg == 2'h0 && sh[7:1] != {DEV_ADDR_HI, addr_sel}) begin
          act  <= 1'b0;
          pull <= 1'b0;
        end
        if (stg == 2'h0) rd <= sh[0];
        if (stg == 2'h1) ptr <= sh;
        if (stg == 2'h2) begin
          regs[ptr] <= sh;
          ptr       <= ptr + 8'h01;
        end
      end
    end
  end
endmodule

// [testbench/two_wire_config_port_bench.sv]
// Self-checking bench for the two-wire configuration port host.
// Assumes twcp_host and the device model; xtal_clk is unrelated to sys_clk.
`timescale 1ns/1ps

module two_wire_config_port_bench
  import twcp_pkg::*;
;
  logic         sys_clk = 1'b0, xtal_clk = 1'b0, rst_b = 1'b0;
  logic         cmd_valid = 1'b0, init_req = 1'b0, dev_reset_req = 1'b0;
  logic         addr_sel = 1'b0, dev_sel = 1'b0;
  twcp_cmd_type cmd = '0;
  logic [7:0]   crystal_comp = 8'h16;
  logic         cmd_ready, done, nack_err, rd_valid, scl_out, sda_out, sda_oe;
  logic         dev_reset_n, pull;
  logic [7:0]   rd_data;
  logic [7:0]   rq [$];
  int           err_count = 0;
  int           n_compared = 0;
  wire          sda = (sda_oe | pull) ? 1'b0 : 1'b1;

  twcp_host dut (.sys_clk(sys_clk), .rst_b(rst_b), .cmd_valid(cmd_valid), .cmd(cmd),
    .init_req(init_req), .crystal_comp(crystal_comp), .dev_reset_req(dev_reset_req),
    .addr_sel(addr_sel), .cmd_ready(cmd_ready), .done(done), .nack_err(nack_err),
    .rd_valid(rd_valid), .rd_data(rd_data), .scl_out(scl_out), .sda_in(sda),
    .sda_out(sda_out), .sda_oe(sda_oe), .dev_reset_n(dev_reset_n));
  twcp_dev_model dev (.xtal_clk(xtal_clk), .reset_n(dev_reset_n), .addr_sel(dev_sel),
    .scl(scl_out), .sda(sda), .pull(pull));

  // ==========================================================================
  // Clocks, watchdog and shared tasks
  initial forever #5 sys_clk = ~sys_clk;
  initial begin
    #3;
    forever #16 xtal_clk = ~xtal_clk;
  end
  initial begin
    repeat (90000) @(posedge sys_clk);
    err_count++;
    $display("[FAIL] %0t watchdog expired", $time);
    conclude();
  end

  task automatic conclude();
    if (err_count == 0 && n_compared > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask

  task automatic chk(input logic [7:0] got, input logic [7:0] exp, input string what);
    n_compared++;
    if (got !== exp) begin
      err_count++;
      $display("[FAIL] %0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask

  task automatic run_cmd(input logic r, input logic [7:0] p, input logic [7:0] d);
    @(negedge sys_clk);
    cmd       = '{rd: r, ptr: p, data: d, count: 5'h02};
    cmd_valid = 1'b1;
    @(negedge sys_clk);
    cmd_valid = 1'b0;
    @(posedge sys_clk iff done === 1'b1);
    #1;
  endtask

  // Read data is collected as it appears; the open-drain output must never drive high
  always @(posedge sys_clk) begin
    if (rd_valid === 1'b1) rq.push_back(rd_data);
    if (sda_out !== 1'b0) chk(8'(sda_out), 8'h00, "sda_out driven");
  end

  // ==========================================================================
  // Scenarios
  task automatic t_idle();
    chk(8'(scl_out), 8'h01, "idle scl");
    chk(8'(sda_oe), 8'h00, "idle sda");
    chk(8'(dev_reset_n), 8'h01, "idle reset pin");
    chk(8'(cmd_ready), 8'h01, "idle ready");
  endtask

  task automatic t_init();
    @(negedge sys_clk);
    init_req = 1'b1;
    @(negedge sys_clk);
    init_req = 1'b0;
    @(posedge sys_clk iff done === 1'b1);
    #1;
    chk(8'(nack_err), 8'h00, "init acked");
    chk(dev.regs[8'h1C], 8'h49, "tuning");
    chk(dev.regs[8'h23], 8'h78, "restore");
    chk(dev.regs[8'h2B], 8'h16, "crystal");
    chk(dev.regs[8'h1D], 8'hE2, "neighbour kept");
  endtask

  task automatic t_read();
    rq.delete();
    run_cmd(1'b1, 8'h23, 8'h00);
    chk(8'(rq.size()), 8'h02, "read count");
    chk(rq[0], 8'h78, "first byte");
    chk(rq[1], 8'hDB, "next byte default");
    chk(8'(nack_err), 8'h00, "read acked");
  endtask

  task automatic t_nack();
    dev_sel = 1'b1;
    run_cmd(1'b0, 8'h00, 8'h11);
    chk(8'(nack_err), 8'h01, "foreign address");
    chk(dev.regs[8'h00], 8'hFF, "no write");
    dev_sel = 1'b0;
  endtask

  task automatic t_sel();
    @(negedge sys_clk);
    addr_sel = 1'b1;
    dev_sel  = 1'b1;
    repeat (3) @(negedge sys_clk);
    run_cmd(1'b0, 8'h30, 8'h5A);
    chk(8'(nack_err), 8'h00, "select high acked");
    chk(dev.regs[8'h30], 8'h5A, "select high write");
    @(negedge sys_clk);
    addr_sel = 1'b0;
    dev_sel  = 1'b0;
  endtask

  task automatic t_devrst();
    @(negedge sys_clk);
    dev_reset_req = 1'b1;
    @(negedge sys_clk);
    dev_reset_req = 1'b0;
    @(posedge sys_clk iff dev_reset_n === 1'b0);
    @(posedge sys_clk iff done === 1'b1);
    #1;
    chk(8'(dev_reset_n), 8'h01, "reset released");
    chk(dev.regs[8'h1C], 8'hE3, "defaults back");
  endtask

  initial begin
    repeat (2) @(posedge sys_clk);
    @(negedge sys_clk);
    rst_b = 1'b1;
    t_idle();
    t_init();
    t_read();
    t_nack();
    t_sel();
    t_devrst();
    conclude();
  end
endmodule
